// ---- digital_io_routing_control.sv ----
`timescale 1ns/1ns
`include "io_routing_params.svh"

module digital_io_routing_control #(
  parameter int SAMPLE_CYCLES    = `IO_SAMPLE_TIME_NS / `IO_CLK_PERIOD_NS,
  parameter int LED_TOGGLE_TICKS = `IO_LED_TOGGLE_MS
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        obj_wr,
  input  wire logic        obj_rd,
  input  wire logic [15:0] obj_index,
  input  wire logic [7:0]  obj_subindex,
  input  wire logic [31:0] obj_wdata,
  output logic [31:0]      obj_rdata_ff,
  output logic             obj_ack_ff,
  output logic             obj_err_ff,
  input  wire logic [15:0] phys_in,
  input  wire logic [2:0]  hall_in,
  input  wire logic [2:0]  enc_in,
  input  wire logic [31:0] routed_out,
  input  wire logic        fault_reset,
  output logic [15:0]      phys_out,
  output logic             brake_pin_o,
  output logic             brake_pin_oe,
  output logic             motion_permit_ff,
  output logic             fault_req_ff,
  output logic [15:0]      fault_reaction_ff,
  output logic             led_green_ff,
  output logic             led_red_ff
);

  localparam int CW = $clog2(SAMPLE_CYCLES + 1);
  localparam int LW = $clog2(LED_TOGGLE_TICKS + 1);

  // Pin synchronisers and millisecond filter.
  logic [21:0] sync1_ff, sync2_ff, samp_ff, filt_ff;
  logic [CW-1:0] tick_cnt_ff;
  logic          tick_ff;
  wire  logic    tick_end = (tick_cnt_ff == CW'(SAMPLE_CYCLES - 1));

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sync1_ff    <= '0;
      sync2_ff    <= '0;
      tick_cnt_ff <= '0;
      tick_ff     <= 1'b0;
    end else begin
      sync1_ff    <= {enc_in, hall_in, phys_in};
      sync2_ff    <= sync1_ff;
      tick_cnt_ff <= tick_end ? '0 : CW'(tick_cnt_ff + 1'b1);
      tick_ff     <= tick_end;
    end
  end

  // A level is taken only when two millisecond samples agree.
  wire logic [21:0] nxt_filt = tick_ff ? ((samp_ff & sync2_ff) | (filt_ff & (samp_ff ^ sync2_ff))) : filt_ff;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      samp_ff <= '0;
      filt_ff <= '0;
    end else begin
      samp_ff <= tick_ff ? sync2_ff : samp_ff;
      filt_ff <= nxt_filt;
    end
  end

  // Object decode.
  wire logic hit_sfm   = (obj_index == `IO_IDX_IN_CFG) && (obj_subindex == `IO_SUB_SFM);
  wire logic hit_inrt  = (obj_index == `IO_IDX_IN_CFG) && (obj_subindex == `IO_SUB_IN_ROUTE);
  wire logic hit_tbl   = (obj_index == `IO_IDX_IN_TABLE) && (obj_subindex >= `IO_SUB_TABLE_FIRST)
                         && (obj_subindex <= `IO_SUB_TABLE_LAST);
  wire logic hit_unus  = (obj_index == `IO_IDX_OUT_CFG) && (obj_subindex == `IO_SUB_OUT_UNUSED);
  wire logic hit_inv   = (obj_index == `IO_IDX_OUT_CFG) && (obj_subindex == `IO_SUB_OUT_INVERT);
  wire logic hit_men   = (obj_index == `IO_IDX_OUT_CFG) && (obj_subindex == `IO_SUB_MAN_EN);
  wire logic hit_mval  = (obj_index == `IO_IDX_OUT_CFG) && (obj_subindex == `IO_SUB_MAN_VAL);
  wire logic hit_appl  = (obj_index == `IO_IDX_OUT_CFG) && (obj_subindex == `IO_SUB_APPLIED);
  wire logic hit_ourt  = (obj_index == `IO_IDX_OUT_CFG) && (obj_subindex == `IO_SUB_OUT_ROUTE);
  wire logic hit_led   = (obj_index == `IO_IDX_OUT_CFG) && (obj_subindex == `IO_SUB_LED);
  wire logic hit_din   = (obj_index == `IO_IDX_DIN) && (obj_subindex == `IO_SUB_DIN);
  wire logic hit_dout  = (obj_index == `IO_IDX_DOUT) && (obj_subindex == `IO_SUB_DOUT);
  wire logic hit_react = (obj_index == `IO_IDX_FAULT_REACT) && (obj_subindex == `IO_SUB_FAULT_REACT);
  wire logic hit_ro    = hit_appl || hit_din;
  wire logic hit_any   = hit_sfm || hit_inrt || hit_tbl || hit_unus || hit_inv || hit_men || hit_mval
                         || hit_ourt || hit_led || hit_dout || hit_react || hit_ro;
  wire logic [4:0] tbl_sel = 5'(obj_subindex - `IO_SUB_TABLE_FIRST);
  wire logic wr_ok       = obj_wr && hit_any && !hit_ro;

  // Configuration objects.
  logic [31:0] sfm_ff, in_route_ff, inv_ff, man_en_ff, man_val_ff, out_route_ff, led_ctl_ff, dout_ff;
  logic [7:0]  table_ff [32];
  wire  logic  in_route_on  = (in_route_ff == `IO_ROUTE_ON_VALUE);
  wire  logic  out_route_on = (out_route_ff == `IO_ROUTE_ON_VALUE);
  wire  logic  route_load   = wr_ok && hit_inrt && (obj_wdata == `IO_ROUTE_ON_VALUE) && !in_route_on;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sfm_ff            <= `IO_RST_WORD;
      in_route_ff       <= `IO_RST_WORD;
      inv_ff            <= `IO_RST_WORD;
      man_en_ff         <= `IO_RST_WORD;
      man_val_ff        <= `IO_RST_WORD;
      out_route_ff      <= `IO_RST_WORD;
      led_ctl_ff        <= `IO_RST_WORD;
      dout_ff           <= `IO_RST_WORD;
      fault_reaction_ff <= `IO_RST_REACT;
    end else if (wr_ok) begin
      if (hit_sfm) sfm_ff <= obj_wdata;
      if (hit_inrt) in_route_ff <= obj_wdata;
      if (hit_inv) inv_ff <= obj_wdata;
      if (hit_men) man_en_ff <= obj_wdata;
      if (hit_mval) man_val_ff <= obj_wdata;
      if (hit_ourt) out_route_ff <= obj_wdata;
      if (hit_led) led_ctl_ff <= obj_wdata;
      if (hit_dout) dout_ff <= obj_wdata;
      if (hit_react) fault_reaction_ff <= obj_wdata[15:0];
    end
  end

  // Table entries, reloaded with the fixed mapping each time routing is switched on.
  io_routing_pkg::src_vec_type srcs;
  logic [31:0]                 sel_bit;
  assign srcs = filt_ff;

  genvar g;
  generate
    for (g = 0; g < 32; g++) begin : gen_route
      localparam logic [7:0] DEF_CODE = 8'((g % 16) + 1);
      always_ff @(posedge clk) begin
        if (!rst_n) begin
          table_ff[g] <= DEF_CODE;
        end else if (route_load) begin
          table_ff[g] <= DEF_CODE;
        end else if (wr_ok && hit_tbl && (tbl_sel == 5'(g))) begin
          table_ff[g] <= obj_wdata[7:0];
        end
      end
      io_source_select u_sel (
        .code    (table_ff[g]),
        .sources (srcs),
        .level   (sel_bit[g])
      );
    end
  endgenerate

  // Digital input word: special functions low, plain levels high.
  logic [31:0] din_ff;
  wire  logic [31:0] fixed_din = {filt_ff[15:0], filt_ff[15:0]};
  wire  logic [31:0] nxt_din   = in_route_on ? sel_bit : fixed_din;

  always_ff @(posedge clk) begin
    if (!rst_n) din_ff <= `IO_RST_WORD;
    else din_ff <= nxt_din;
  end

  // Interlock.
  io_routing_pkg::ilk_state_type ilk_state_ff, nxt_ilk_state;
  wire logic ilk_trip = sfm_ff[`IO_INTERLOCK_BIT] && !din_ff[`IO_INTERLOCK_BIT];

  always_comb begin
    nxt_ilk_state = ilk_state_ff;
    case (ilk_state_ff)
      io_routing_pkg::ILK_RUN: begin
        if (ilk_trip) nxt_ilk_state = io_routing_pkg::ILK_FAULT;
      end
      io_routing_pkg::ILK_FAULT: begin
        if (fault_reset && !ilk_trip) nxt_ilk_state = io_routing_pkg::ILK_RUN;
      end
      default: nxt_ilk_state = io_routing_pkg::ILK_FAULT;
    endcase
  end

  wire logic in_error = (nxt_ilk_state == io_routing_pkg::ILK_FAULT);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ilk_state_ff     <= io_routing_pkg::ILK_RUN;
      motion_permit_ff <= 1'b0;
      fault_req_ff     <= 1'b0;
    end else begin
      ilk_state_ff     <= nxt_ilk_state;
      motion_permit_ff <= !in_error;
      fault_req_ff     <= in_error && (ilk_state_ff == io_routing_pkg::ILK_RUN);
    end
  end

  // Output path: source, inversion, manual override.
  logic [31:0] applied_ff;
  logic        brake_oe_ff;
  wire  logic [31:0] cmd_src     = out_route_on ? routed_out : dout_ff;
  wire  logic [31:0] nxt_applied = (man_en_ff & man_val_ff) | (~man_en_ff & (cmd_src ^ inv_ff));

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      applied_ff  <= `IO_RST_WORD;
      brake_oe_ff <= 1'b1;
    end else begin
      applied_ff  <= nxt_applied;
      brake_oe_ff <= !nxt_applied[`IO_BRAKE_BIT];
    end
  end

  // Open drain brake pin only ever pulls low.
  assign phys_out     = applied_ff[31:`IO_LEVEL_BASE];
  assign brake_pin_o  = 1'b0;
  assign brake_pin_oe = brake_oe_ff;

  // Status LED flashing off the millisecond tick.
  logic [LW-1:0] led_cnt_ff;
  logic          blink_ff;
  wire  logic    led_wrap = tick_ff && (led_cnt_ff == LW'(LED_TOGGLE_TICKS - 1));

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      led_cnt_ff   <= '0;
      blink_ff     <= 1'b0;
      led_green_ff <= 1'b0;
      led_red_ff   <= 1'b0;
    end else begin
      led_cnt_ff   <= led_wrap ? '0 : (tick_ff ? LW'(led_cnt_ff + 1'b1) : led_cnt_ff);
      blink_ff     <= led_wrap ? !blink_ff : blink_ff;
      led_green_ff <= led_ctl_ff[`IO_LED_GREEN_BIT] && !in_error && blink_ff;
      led_red_ff   <= led_ctl_ff[`IO_LED_RED_BIT] && in_error && blink_ff;
    end
  end

  // Read mux.
  logic [31:0] rd_val;
  always_comb begin
    if (hit_sfm) rd_val = sfm_ff;
    else if (hit_inrt) rd_val = in_route_ff;
    else if (hit_tbl) rd_val = {24'h000000, table_ff[tbl_sel]};
    else if (hit_inv) rd_val = inv_ff;
    else if (hit_men) rd_val = man_en_ff;
    else if (hit_mval) rd_val = man_val_ff;
    else if (hit_appl) rd_val = applied_ff;
    else if (hit_ourt) rd_val = out_route_ff;
    else if (hit_led) rd_val = led_ctl_ff;
    else if (hit_din) rd_val = din_ff;
    else if (hit_dout) rd_val = dout_ff;
    else if (hit_react) rd_val = {16'h0000, fault_reaction_ff};
    else rd_val = 32'h00000000;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      obj_rdata_ff <= `IO_RST_WORD;
      obj_ack_ff   <= 1'b0;
      obj_err_ff   <= 1'b0;
    end else begin
      obj_rdata_ff <= (obj_rd && !obj_wr) ? rd_val : obj_rdata_ff;
      obj_ack_ff   <= obj_wr || obj_rd;
      obj_err_ff   <= (obj_wr || obj_rd) && (!hit_any || (obj_wr && hit_ro));
    end
  end

  default clocking dcb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  sequence s_route_enable;
    obj_wr && hit_inrt && (obj_wdata == `IO_ROUTE_ON_VALUE) && !in_route_on;
  endsequence

  sequence s_default_table;
    (table_ff[0] == 8'h01) && (table_ff[3] == 8'h04) && (table_ff[16] == 8'h01) && (table_ff[31] == 8'h10);
  endsequence

  a_route_defaults: assert property (s_route_enable |=> s_default_table)
    else $error("Routing enable did not load default table.");
  a_fixed_map: assert property (!in_route_on |=> din_ff == {$past(filt_ff[15:0]), $past(filt_ff[15:0])})
    else $error("Fixed input mapping wrong.");
  a_entry_bit3: assert property (in_route_on && (table_ff[3] == 8'h80) |=> din_ff[3])
    else $error("Code 80 did not give constant one.");
  a_entry_zero: assert property (in_route_on && (table_ff[0] == 8'h00) |=> !din_ff[0])
    else $error("Code 00 did not give constant zero.");
  a_entry_hall: assert property (in_route_on && (table_ff[0] == 8'h41) |=> din_ff[0] == $past(filt_ff[16]))
    else $error("Hall U not routed to its bit.");
  a_interlock_trip: assert property (ilk_trip |=> !motion_permit_ff ##0 (ilk_state_ff == io_routing_pkg::ILK_FAULT))
    else $error("Interlock did not stop motion.");
  a_output_map: assert property (!man_en_ff[17] && !inv_ff[17] && !out_route_on |=> phys_out[1] == $past(dout_ff[17]))
    else $error("Output 2 does not follow bit 17.");
  a_manual_force: assert property (man_en_ff[16] |=> applied_ff[16] == $past(man_val_ff[16]))
    else $error("Manual value not applied.");
  a_invert_out: assert property (!man_en_ff[17] && inv_ff[17] && !out_route_on && dout_ff[17] |=> !applied_ff[17])
    else $error("Inverted output not low for one.");
  a_led_off: assert property (!led_ctl_ff[0] |=> !led_green_ff)
    else $error("Green LED lit while disabled.");
  a_filter_hold: assert property (!tick_ff |=> $stable(filt_ff))
    else $error("Filtered input changed off the sample tick.");

endmodule : digital_io_routing_control

// ---- io_routing_params.svh ----
`ifndef IO_ROUTING_PARAMS_SVH
`define IO_ROUTING_PARAMS_SVH

// Object locations: 16-bit index and 8-bit subindex.
`define IO_IDX_IN_CFG       16'h3240
`define IO_IDX_IN_TABLE     16'h3242
`define IO_IDX_OUT_CFG      16'h3250
`define IO_IDX_DIN          16'h60FD
`define IO_IDX_DOUT         16'h60FE
`define IO_IDX_FAULT_REACT  16'h605E
`define IO_SUB_SFM          8'h01
`define IO_SUB_IN_ROUTE     8'h08
`define IO_SUB_OUT_UNUSED   8'h01
`define IO_SUB_OUT_INVERT   8'h02
`define IO_SUB_MAN_EN       8'h03
`define IO_SUB_MAN_VAL      8'h04
`define IO_SUB_APPLIED      8'h05
`define IO_SUB_OUT_ROUTE    8'h08
`define IO_SUB_LED          8'h09
`define IO_SUB_DIN          8'h00
`define IO_SUB_DOUT         8'h01
`define IO_SUB_FAULT_REACT  8'h00
`define IO_SUB_TABLE_FIRST  8'h01
`define IO_SUB_TABLE_LAST   8'h20

// Field positions and the routing enable value.
`define IO_ROUTE_ON_VALUE   32'h00000001
`define IO_INTERLOCK_BIT    3
`define IO_BRAKE_BIT        0
`define IO_LEVEL_BASE       16
`define IO_LED_GREEN_BIT    0
`define IO_LED_RED_BIT      1
`define IO_SRC_INVERT_BIT   7

// Source codes.
`define IO_SRC_PHYS_FIRST   7'h01
`define IO_SRC_PHYS_LAST    7'h10
`define IO_SRC_SENS_FIRST   7'h41
`define IO_SRC_SENS_LAST    7'h46
`define IO_SRC_SENS_SLOT    5'h10

// Reset values.
`define IO_RST_WORD         32'h00000000
`define IO_RST_REACT        16'h0000

// Timing.
`define IO_SAMPLE_TIME_NS   1000000
`define IO_CLK_PERIOD_NS    8
`define IO_LED_TOGGLE_MS    250

`endif

// ---- io_routing_pkg.sv ----
package io_routing_pkg;

  typedef enum logic [1:0] {
    ILK_RUN   = 2'b01,
    ILK_FAULT = 2'b10
  } ilk_state_type;

  typedef logic [7:0]  src_code_type;
  typedef logic [21:0] src_vec_type;

endpackage : io_routing_pkg

// ---- io_source_select.sv ----
`timescale 1ns/1ns
`include "io_routing_params.svh"

module io_source_select (
  input  wire logic [7:0]  code,
  input  wire logic [21:0] sources,
  output logic             level
);

  wire logic [6:0] base     = code[6:0];
  wire logic       is_phys  = (base >= `IO_SRC_PHYS_FIRST) && (base <= `IO_SRC_PHYS_LAST);
  wire logic       is_sens  = (base >= `IO_SRC_SENS_FIRST) && (base <= `IO_SRC_SENS_LAST);
  wire logic [4:0] phys_pos = 5'(base - `IO_SRC_PHYS_FIRST);
  wire logic [4:0] sens_pos = 5'(base - `IO_SRC_SENS_FIRST) + `IO_SRC_SENS_SLOT;
  // Unknown codes fall back to constant zero before the inversion bit acts.
  wire logic       raw      = is_phys ? sources[phys_pos] : (is_sens ? sources[sens_pos] : 1'b0);

  assign level = raw ^ code[`IO_SRC_INVERT_BIT];

endmodule : io_source_select

// ---- io_field_model.sv ----
`timescale 1ns/1ns
module io_field_model (
  input  wire logic        clk,
  input  wire logic [15:0] phys_set,
  input  wire logic [5:0]  sens_set,
  input  wire logic        brake_pin_o,
  input  wire logic        brake_pin_oe,
  output logic [15:0]      phys_in,
  output logic [2:0]       hall_in,
  output logic [2:0]       enc_in,
  output logic             brake_line
);
  // Apart from one 7-clock pin pulse, switch and sensor levels move once per step and then hold for many sample ticks.
  always @(posedge clk) begin
    phys_in <= phys_set;
    {enc_in, hall_in} <= sens_set;
  end
  // The brake line is open drain with an external pull-up.
  assign brake_line = brake_pin_oe ? brake_pin_o : 1'b1;
endmodule : io_field_model

// ---- digital_io_routing_control_tb.sv ----
`timescale 1ns/1ns
module digital_io_routing_control_tb;
  typedef struct packed {logic err; logic chk; logic [31:0] data;} note_type;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        obj_wr = 1'b0;
  logic        obj_rd = 1'b0;
  logic [15:0] obj_index = 16'h0000;
  logic [7:0]  obj_subindex = 8'h00;
  logic [31:0] obj_wdata = 32'h00000000;
  logic [31:0] routed_out = 32'h00000000;
  logic        fault_reset = 1'b0;
  logic [15:0] phys_set = 16'h0000;
  logic [5:0]  sens_set = 6'h00;
  logic [31:0] obj_rdata_ff;
  logic        obj_ack_ff, obj_err_ff, brake_pin_o, brake_pin_oe, brake_line;
  logic        motion_permit_ff, fault_req_ff, led_green_ff, led_red_ff;
  logic [15:0] phys_in, phys_out, fault_reaction_ff;
  logic [2:0]  hall_in, enc_in;
  int          mismatches = 0;
  int          comparisons = 0;
  int          cycles = 0;
  logic [31:0] xs_state = 32'hDB727856;
  logic [7:0]  tbl [32];
  note_type    notes [$];
  note_type    n;

  digital_io_routing_control #(.SAMPLE_CYCLES(8), .LED_TOGGLE_TICKS(2)) i_digital_io_routing_control (
    .clk, .rst_n, .obj_wr, .obj_rd, .obj_index, .obj_subindex, .obj_wdata, .obj_rdata_ff,
    .obj_ack_ff, .obj_err_ff, .phys_in, .hall_in, .enc_in, .routed_out, .fault_reset,
    .phys_out, .brake_pin_o, .brake_pin_oe, .motion_permit_ff, .fault_req_ff,
    .fault_reaction_ff, .led_green_ff, .led_red_ff);

  io_field_model i_io_field_model (
    .clk, .phys_set, .sens_set, .brake_pin_o, .brake_pin_oe, .phys_in, .hall_in, .enc_in, .brake_line);

  always #4 clk = ~clk;

  function automatic logic [31:0] xs();
    xs_state ^= xs_state << 13;
    xs_state ^= xs_state >> 17;
    xs_state ^= xs_state << 5;
    return xs_state;
  endfunction : xs

  function automatic logic [31:0] din_exp();
    logic [31:0] d;
    logic [6:0]  c;
    for (int k = 0; k < 32; k++) begin
      c = tbl[k][6:0];
      d[k] = tbl[k][7];
      if (c >= 7'h01 && c <= 7'h10) d[k] ^= phys_set[c - 7'h01];
      else if (c >= 7'h41 && c <= 7'h46) d[k] ^= sens_set[c - 7'h41];
    end
    return d;
  endfunction : din_exp

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : complete_run

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic tick(input int k);
    repeat (k) @(posedge clk);
  endtask : tick

  task automatic access(input logic wr, input logic [15:0] idx, input logic [7:0] sub,
                        input logic [31:0] wd, input logic err, input logic [31:0] exp);
    obj_wr <= wr;
    obj_rd <= !wr;
    obj_index <= idx;
    obj_subindex <= sub;
    obj_wdata <= wd;
    notes.push_back({err, !wr && !err, exp});
    @(posedge clk);
    obj_wr <= 1'b0;
    obj_rd <= 1'b0;
    @(posedge clk);
  endtask : access

  task automatic leds(output int g, output int r);
    logic pg, pr;
    g = 0;
    r = 0;
    pg = led_green_ff;
    pr = led_red_ff;
    repeat (64) begin
      @(posedge clk);
      g += (led_green_ff !== pg);
      r += (led_red_ff !== pr);
      pg = led_green_ff;
      pr = led_red_ff;
    end
  endtask : leds

  // Every acknowledge retires the oldest note of the driver.
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (obj_ack_ff === 1'b1) begin
      if (notes.size() == 0) check("spare_ack", 32'h0, 32'h1);
      else begin
        n = notes.pop_front();
        check("obj_err", {31'h0, n.err}, {31'h0, obj_err_ff});
        if (n.chk) check("obj_rdata", n.data, obj_rdata_ff);
      end
    end
    if (cycles == 20000) begin
      mismatches++;
      complete_run();
    end
  end

  initial begin
    logic [31:0] r, dout, inv, men, mval, ro, app;
    logic [7:0]  c;
    int          g, rt, w;
    repeat (16) @(posedge clk);
    check("brake_oe_rst", 32'h1, {31'h0, brake_pin_oe});
    check("phys_out_rst", 32'h0, {16'h0, phys_out});
    rst_n <= 1'b1;
    r = xs();
    phys_set <= r[15:0];
    sens_set <= r[21:16];
    tick(48);
    access(1, 16'h3240, 8'h08, 32'h1, 0, 0);
    for (int k = 0; k < 32; k++) begin
      tbl[k] = 8'((k % 16) + 1);
      access(0, 16'h3242, 8'(k + 1), 0, 0, {24'h0, tbl[k]});
    end
    access(0, 16'h60FD, 8'h00, 0, 0, din_exp());
    for (int k = 0; k < 46; k++) begin
      c = (k / 2 == 0) ? 8'h00 : (k / 2 <= 16) ? 8'(k / 2) : 8'(k / 2 + 48);
      tbl[0] = {k[0], c[6:0]};
      access(1, 16'h3242, 8'h01, {24'h0, tbl[0]}, 0, 0);
      tick(2);
      access(0, 16'h60FD, 8'h00, 0, 0, din_exp());
    end
    repeat (4) begin
      r = xs();
      phys_set <= r[15:0];
      sens_set <= r[21:16];
      for (int k = 0; k < 32; k++) begin
        r = xs();
        tbl[k] = r[9:8] == 2'd0 ? {r[7], 3'h0, r[3:0] + 4'h1} :
                 r[9:8] == 2'd1 ? {r[7], 7'h41 + 7'(r[2:0]) % 7'd6} : r[7:0];
        access(1, 16'h3242, 8'(k + 1), {24'h0, tbl[k]}, 0, 0);
      end
      tick(48);
      access(0, 16'h60FD, 8'h00, 0, 0, din_exp());
    end
    // A pin pulse shorter than one sample period must never reach the input word.
    phys_set <= ~phys_set;
    tick(7);
    phys_set <= ~phys_set;
    tick(1);
    repeat (16) access(0, 16'h60FD, 8'h00, 0, 0, din_exp());
    access(1, 16'h3240, 8'h08, 32'h0, 0, 0);
    tick(2);
    access(0, 16'h60FD, 8'h00, 0, 0, {phys_set, phys_set});
    access(1, 16'h3240, 8'h08, 32'h1, 0, 0);
    access(0, 16'h3242, 8'h20, 0, 0, 32'h10);
    for (int k = 0; k < 8; k++) begin
      dout = xs();
      inv = xs();
      men = xs() & xs();
      mval = xs();
      ro = xs();
      routed_out <= ro;
      access(1, 16'h60FE, 8'h01, dout, 0, 0);
      access(1, 16'h3250, 8'h02, inv, 0, 0);
      access(1, 16'h3250, 8'h03, men, 0, 0);
      access(1, 16'h3250, 8'h04, mval, 0, 0);
      access(1, 16'h3250, 8'h08, {31'h0, k >= 4}, 0, 0);
      tick(3);
      app = (men & mval) | (~men & ((k >= 4 ? ro : dout) ^ inv));
      access(0, 16'h3250, 8'h05, 0, 0, app);
      check("phys_out", {16'h0, app[31:16]}, {16'h0, phys_out});
      check("brake_line", {31'h0, app[0]}, {31'h0, brake_line});
      access(0, 16'h3250, 8'h02, 0, 0, inv);
    end
    access(0, 16'h1234, 8'h00, 0, 1, 0);
    access(1, 16'h3250, 8'h05, 32'hFFFFFFFF, 1, 0);
    access(1, 16'h3250, 8'h01, 32'hFFFFFFFF, 0, 0);
    access(0, 16'h3250, 8'h01, 0, 0, 0);
    r = xs();
    access(1, 16'h605E, 8'h00, r, 0, 0);
    check("fault_reaction", {16'h0, r[15:0]}, {16'h0, fault_reaction_ff});
    access(1, 16'h3250, 8'h09, 32'h3, 0, 0);
    access(1, 16'h3242, 8'h04, 32'h80, 0, 0);
    tick(4);
    access(1, 16'h3240, 8'h01, 32'h8, 0, 0);
    tick(4);
    check("permit_run", 32'h1, {31'h0, motion_permit_ff});
    leds(g, rt);
    check("green_run", 32'h1, {31'h0, g >= 2});
    check("red_run", 32'h0, rt);
    access(1, 16'h3242, 8'h04, 32'h00, 0, 0);
    w = 0;
    while (fault_req_ff !== 1'b1 && w < 20) begin
      @(posedge clk);
      w++;
    end
    check("fault_req", 32'h1, {31'h0, fault_req_ff});
    @(posedge clk);
    check("fault_req_end", 32'h0, {31'h0, fault_req_ff});
    check("permit_fault", 32'h0, {31'h0, motion_permit_ff});
    leds(g, rt);
    check("green_fault", 32'h0, g);
    check("red_fault", 32'h1, {31'h0, rt >= 2});
    fault_reset <= 1'b1;
    @(posedge clk);
    fault_reset <= 1'b0;
    tick(3);
    check("permit_held", 32'h0, {31'h0, motion_permit_ff});
    access(1, 16'h3242, 8'h04, 32'h80, 0, 0);
    tick(3);
    fault_reset <= 1'b1;
    @(posedge clk);
    fault_reset <= 1'b0;
    tick(3);
    check("permit_back", 32'h1, {31'h0, motion_permit_ff});
    tick(4);
    check("notes_left", 32'h0, notes.size());
    complete_run();
  end
endmodule : digital_io_routing_control_tb
